// ---- hw/rtcb_cal_step.sv ----
`timescale 1ns/1ps
module rtcb_cal_step (
    input rtcb_pkg::rtcb_cal_t cur,
    input wire logic h24,
    input wire logic tick,
    input wire logic adj30,
    output rtcb_pkg::rtcb_cal_t nxt
);

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic is_leap(input logic [7:0] y);
        is_leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                       : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    endfunction

    function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
        case (m)
            8'h02: last_day = is_leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            default: last_day = 8'h31;
        endcase
    endfunction

    logic c_min;
    logic c_hour;
    logic c_day;
    logic c_mon;
    logic c_year;

    // ------------------------------------------------------------
    // BCD cascade
    // ------------------------------------------------------------
    always_comb begin
        nxt = cur;
        c_min = 1'b0;
        c_hour = 1'b0;
        c_day = 1'b0;
        c_mon = 1'b0;
        c_year = 1'b0;
        if (adj30) begin
            nxt.sec = 8'h00;
            c_min = (cur.sec >= 8'h30);
        end else if (tick) begin
            nxt.sec = (cur.sec == 8'h59) ? 8'h00 : bcd_inc(cur.sec);
            c_min = (cur.sec == 8'h59);
        end
        if (c_min) begin
            nxt.min = (cur.min == 8'h59) ? 8'h00 : bcd_inc(cur.min);
            c_hour = (cur.min == 8'h59);
        end
        if (c_hour) begin
            if (h24) begin
                nxt.hour = (cur.hour == 8'h23) ? 8'h00 : bcd_inc(cur.hour);
                c_day = (cur.hour == 8'h23);
            end else if (cur.hour == 8'h11) begin
                nxt.hour = 8'h12;
                nxt.pm = ~cur.pm;
                c_day = cur.pm;
            end else begin
                nxt.hour = (cur.hour == 8'h12) ? 8'h01 : bcd_inc(cur.hour);
            end
        end
        if (c_day) begin
            nxt.wday = (cur.wday == 3'h6) ? 3'h0 : cur.wday + 3'h1;
            c_mon = (cur.day == last_day(cur.month, cur.year));
            nxt.day = c_mon ? 8'h01 : bcd_inc(cur.day);
        end
        if (c_mon) begin
            c_year = (cur.month == 8'h12);
            nxt.month = c_year ? 8'h01 : bcd_inc(cur.month);
        end
        if (c_year) begin
            nxt.year = (cur.year == 8'h99) ? 8'h00 : bcd_inc(cur.year);
        end
    end

endmodule // rtcb_cal_step

// ---- hw/rtcb_pkg.sv ----
package rtcb_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses on the local port)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_SUBSEC = 8'h0C;
    localparam logic [7:0] OFF_TIME = 8'h10;
    localparam logic [7:0] OFF_DATE = 8'h14;
    localparam logic [7:0] OFF_BINCNT = 8'h18;
    localparam logic [7:0] OFF_ALM_TIME = 8'h1C;
    localparam logic [7:0] OFF_ALM_DATE = 8'h20;
    localparam logic [7:0] OFF_ALM_EN = 8'h24;
    localparam logic [7:0] OFF_BIN_ALM = 8'h28;
    localparam logic [7:0] OFF_BIN_ALM_EN = 8'h2C;
    localparam logic [7:0] OFF_ADJUST = 8'h30;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_RUN = 0;
    localparam int CTRL_BIN = 1;
    localparam int CTRL_H24 = 2;
    localparam int CTRL_CLK64 = 3;
    localparam int CTRL_SRC_MAIN = 4;
    localparam int CTRL_PES_LSB = 8;
    localparam int CTRL_ADJ30 = 16;
    localparam int ST_ALARM = 0;
    localparam int ST_PERIODIC = 1;
    localparam int ST_CARRY = 2;
    localparam int ADJ_MINUS = 6;
    localparam int ADJ_ENABLE = 7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [7:0] YEAR_RESET = 8'h00;
    localparam logic [7:0] MONTH_RESET = 8'h01;
    localparam logic [7:0] DAY_RESET = 8'h01;

    // ------------------------------------------------------------
    // Counts
    // ------------------------------------------------------------
    localparam int PRESCALE = 128;
    localparam int ADJ_INTERVAL_S = 60;
    localparam logic [3:0] PES_256 = 4'h6;
    localparam logic [3:0] PES_1S = 4'hE;
    localparam logic [3:0] PES_2S = 4'hF;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [2:0] wday;
        logic pm;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } rtcb_cal_t;

endpackage

// ---- hw/rtcb_top.sv ----
`timescale 1ns/1ps
module rtcb_top #(
    parameter int PRE_W = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic subclock_osc_in,
    input wire logic main_osc_in,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq,
    output logic clk_out
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic sub_s1_reg, sub_s2_reg, main_s1_reg, main_s2_reg, src_d_reg;
    logic [31:0] ctrl_reg;
    logic [2:0] status_reg, status_next, mask_reg;
    logic [PRE_W-1:0] pre_reg, pre_next;
    logic [7:0] frac_reg;
    logic sec_par_reg;
    logic [5:0] adj_cnt_reg;
    logic [5:0] adj_left_reg;
    logic adj_add_reg;
    logic [7:0] adjust_reg;
    rtcb_pkg::rtcb_cal_t cal_reg, cal_next, cal_step, alm_cal_reg;
    logic [6:0] alm_en_reg;
    logic [31:0] bin_reg, bin_alm_reg, bin_alm_en_reg;
    logic upd_d_reg;
    logic [31:0] rdata_reg;
    logic irq_reg, clk_out_reg;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic run = ctrl_reg[rtcb_pkg::CTRL_RUN];
    wire logic bin_mode = ctrl_reg[rtcb_pkg::CTRL_BIN];
    wire logic [3:0] period_select = ctrl_reg[rtcb_pkg::CTRL_PES_LSB +: 4];
    wire logic wr_ctrl = wr && addr == rtcb_pkg::OFF_CTRL;
    wire logic wr_status = wr && addr == rtcb_pkg::OFF_STATUS;
    wire logic wr_time = wr && addr == rtcb_pkg::OFF_TIME;
    wire logic wr_date = wr && addr == rtcb_pkg::OFF_DATE;
    wire logic wr_bin = wr && addr == rtcb_pkg::OFF_BINCNT;
    wire logic rd_subsec = rd && addr == rtcb_pkg::OFF_SUBSEC;
    wire logic adj30 = wr_ctrl && wdata[rtcb_pkg::CTRL_ADJ30] && run && !bin_mode;

    // ------------------------------------------------------------
    // Prescaler and sub-second stages
    // ------------------------------------------------------------
    wire logic src_s2 = ctrl_reg[rtcb_pkg::CTRL_SRC_MAIN]
        ? main_s2_reg : sub_s2_reg;
    wire logic src_edge = src_s2 && !src_d_reg;
    wire logic advance = src_edge && run;
    wire logic adj_busy = adj_left_reg != 6'h00;
    wire logic [1:0] pre_step = !adj_busy ? 2'd1 : (adj_add_reg ? 2'd2 : 2'd0);
    wire logic [PRE_W:0] pre_sum = {1'b0, pre_reg} + {{(PRE_W - 1){1'b0}}, pre_step};
    wire logic [PRE_W:0] pre_lim = (PRE_W + 1)'(rtcb_pkg::PRESCALE);
    wire logic tick256 = advance && pre_sum >= pre_lim;
    wire logic [7:0] frac_inc = frac_reg + 8'h01;
    wire logic sec_tick = tick256 && frac_reg == 8'hFF;
    wire logic adj_due = sec_tick && adj_cnt_reg == 6'(rtcb_pkg::ADJ_INTERVAL_S - 1);
    wire logic [6:0] subsecond_counter = frac_reg[7:1];

    assign pre_next = tick256 ? PRE_W'(pre_sum - pre_lim) : PRE_W'(pre_sum);

    function automatic logic period_hit(input logic [3:0] code, input logic [7:0] f,
                                        input logic par);
        case (code)
            4'h6: period_hit = 1'b1;
            4'h7: period_hit = f[0] == 1'b0;
            4'h8: period_hit = f[1:0] == 2'h0;
            4'h9: period_hit = f[2:0] == 3'h0;
            4'hA: period_hit = f[3:0] == 4'h0;
            4'hB: period_hit = f[4:0] == 5'h00;
            4'hC: period_hit = f[5:0] == 6'h00;
            4'hD: period_hit = f[6:0] == 7'h00;
            4'hE: period_hit = f == 8'h00;
            4'hF: period_hit = f == 8'h00 && par;
            default: period_hit = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Calendar and binary counters
    // ------------------------------------------------------------
    rtcb_cal_step rtcb_cal_step_i (
        .cur(cal_reg),
        .h24(ctrl_reg[rtcb_pkg::CTRL_H24]),
        .tick(sec_tick && !bin_mode),
        .adj30(adj30),
        .nxt(cal_step)
    );

    always_comb begin
        cal_next = cal_step;
        if (wr_time) begin
            cal_next.sec = wdata[7:0];
            cal_next.min = wdata[15:8];
            cal_next.hour = wdata[23:16];
            cal_next.wday = wdata[26:24];
            cal_next.pm = wdata[27];
        end
        if (wr_date) begin
            cal_next.day = wdata[7:0];
            cal_next.month = wdata[15:8];
            cal_next.year = wdata[23:16];
        end
    end

    wire logic [31:0] time_word = {4'h0, cal_reg.pm, cal_reg.wday, cal_reg.hour, cal_reg.min,
                                   cal_reg.sec};
    wire logic [31:0] date_word = {8'h00, cal_reg.year, cal_reg.month, cal_reg.day};
    wire logic [31:0] alm_time_word = {4'h0, alm_cal_reg.pm, alm_cal_reg.wday, alm_cal_reg.hour,
                                       alm_cal_reg.min, alm_cal_reg.sec};
    wire logic [31:0] alm_date_word = {8'h00, alm_cal_reg.year, alm_cal_reg.month,
                                       alm_cal_reg.day};

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    wire logic [6:0] cal_eq = {cal_reg.year == alm_cal_reg.year,
                               cal_reg.month == alm_cal_reg.month,
                               cal_reg.day == alm_cal_reg.day,
                               cal_reg.wday == alm_cal_reg.wday,
                               {cal_reg.pm, cal_reg.hour} == {alm_cal_reg.pm, alm_cal_reg.hour},
                               cal_reg.min == alm_cal_reg.min,
                               cal_reg.sec == alm_cal_reg.sec};
    wire logic cal_match = &(cal_eq | ~alm_en_reg);
    wire logic bin_match =
        ((bin_reg ^ bin_alm_reg) & bin_alm_en_reg) == 32'h0000_0000;
    wire logic alarm_irq = upd_d_reg && (bin_mode ? bin_match : cal_match);
    wire logic periodic_irq =
        tick256 && period_hit(period_select, frac_inc, sec_par_reg);
    wire logic carry_irq =
        sec_tick || (rd_subsec && tick256 && frac_reg[0]);
    wire logic [2:0] events = {carry_irq, periodic_irq, alarm_irq};
    wire logic [2:0] clr_bits = wr_status ? wdata[2:0] : 3'h0;

    assign status_next = (status_reg & ~clr_bits) | events;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        case (addr)
            rtcb_pkg::OFF_CTRL: rd_mux = {ctrl_reg[31:17], 1'b0, ctrl_reg[15:0]};
            rtcb_pkg::OFF_STATUS: rd_mux = {29'h0, status_reg};
            rtcb_pkg::OFF_MASK: rd_mux = {29'h0, mask_reg};
            rtcb_pkg::OFF_SUBSEC: rd_mux = {25'h0, subsecond_counter};
            rtcb_pkg::OFF_TIME: rd_mux = time_word;
            rtcb_pkg::OFF_DATE: rd_mux = date_word;
            rtcb_pkg::OFF_BINCNT: rd_mux = bin_reg;
            rtcb_pkg::OFF_ALM_TIME: rd_mux = alm_time_word;
            rtcb_pkg::OFF_ALM_DATE: rd_mux = alm_date_word;
            rtcb_pkg::OFF_ALM_EN: rd_mux = {25'h0, alm_en_reg};
            rtcb_pkg::OFF_BIN_ALM: rd_mux = bin_alm_reg;
            rtcb_pkg::OFF_BIN_ALM_EN: rd_mux = bin_alm_en_reg;
            rtcb_pkg::OFF_ADJUST: rd_mux = {24'h0, adjust_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sub_s1_reg <= 1'b0;
            sub_s2_reg <= 1'b0;
            main_s1_reg <= 1'b0;
            main_s2_reg <= 1'b0;
            src_d_reg <= 1'b0;
        end else if (ce) begin
            sub_s1_reg <= subclock_osc_in;
            sub_s2_reg <= sub_s1_reg;
            main_s1_reg <= main_osc_in;
            main_s2_reg <= main_s1_reg;
            src_d_reg <= src_s2;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= rtcb_pkg::CTRL_RESET;
            mask_reg <= rtcb_pkg::MASK_RESET;
            alm_cal_reg <= '0;
            alm_en_reg <= 7'h00;
            bin_alm_reg <= 32'h0000_0000;
            bin_alm_en_reg <= 32'h0000_0000;
            adjust_reg <= 8'h00;
        end else if (ce && wr) begin
            case (addr)
                rtcb_pkg::OFF_CTRL: ctrl_reg <= {wdata[31:17], 1'b0, wdata[15:0]};
                rtcb_pkg::OFF_MASK: mask_reg <= wdata[2:0];
                rtcb_pkg::OFF_ALM_TIME: begin
                    alm_cal_reg.sec <= wdata[7:0];
                    alm_cal_reg.min <= wdata[15:8];
                    alm_cal_reg.hour <= wdata[23:16];
                    alm_cal_reg.wday <= wdata[26:24];
                    alm_cal_reg.pm <= wdata[27];
                end
                rtcb_pkg::OFF_ALM_DATE: begin
                    alm_cal_reg.day <= wdata[7:0];
                    alm_cal_reg.month <= wdata[15:8];
                    alm_cal_reg.year <= wdata[23:16];
                end
                rtcb_pkg::OFF_ALM_EN: alm_en_reg <= wdata[6:0];
                rtcb_pkg::OFF_BIN_ALM: bin_alm_reg <= wdata;
                rtcb_pkg::OFF_BIN_ALM_EN: bin_alm_en_reg <= wdata;
                rtcb_pkg::OFF_ADJUST: adjust_reg <= wdata[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pre_reg <= '0;
            frac_reg <= 8'h00;
            sec_par_reg <= 1'b0;
            adj_cnt_reg <= 6'h00;
            adj_left_reg <= 6'h00;
            adj_add_reg <= 1'b0;
            cal_reg <= {rtcb_pkg::YEAR_RESET, rtcb_pkg::MONTH_RESET, rtcb_pkg::DAY_RESET, 28'h0};
            bin_reg <= 32'h0000_0000;
            upd_d_reg <= 1'b0;
        end else if (ce) begin
            if (advance) begin
                pre_reg <= pre_next;
                adj_left_reg <= adj_busy ? adj_left_reg - 6'h01 : 6'h00;
            end
            if (adj_due && adjust_reg[rtcb_pkg::ADJ_ENABLE]) begin
                adj_left_reg <= adjust_reg[5:0];
                adj_add_reg <= !adjust_reg[rtcb_pkg::ADJ_MINUS];
            end
            if (tick256) begin
                frac_reg <= frac_inc;
            end
            if (sec_tick) begin
                sec_par_reg <= ~sec_par_reg;
                adj_cnt_reg <= adj_due ? 6'h00 : adj_cnt_reg + 6'h01;
            end
            cal_reg <= cal_next;
            if (wr_bin) begin
                bin_reg <= wdata;
            end else if (sec_tick && bin_mode) begin
                bin_reg <= bin_reg + 32'h0000_0001;
            end
            upd_d_reg <= sec_tick || adj30;
        end
    end

    // ------------------------------------------------------------
    // Status, interrupt, outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_reg <= 3'h0;
            irq_reg <= 1'b0;
            clk_out_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            status_reg <= status_next;
            irq_reg <= |(status_next & mask_reg);
            clk_out_reg <= ctrl_reg[rtcb_pkg::CTRL_CLK64]
                ? frac_reg[1] : frac_reg[7];
            rdata_reg <= rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign rdata = rdata_reg;
    assign irq = irq_reg;
    assign clk_out = clk_out_reg;

endmodule // rtcb_top

// ---- tb/rtcb_top_sva.sv ----
`timescale 1ns/1ps
module rtcb_top_sva #(
    parameter int PRE_W = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic subclock_osc_in,
    input wire logic main_osc_in,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic irq,
    input wire logic clk_out
);
    // ------------------------------------------------------------
    // Shadow of the mask register
    // ------------------------------------------------------------
    logic [2:0] mask_reg;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) mask_reg <= 3'h0;
        else if (ce && wr && addr == rtcb_pkg::OFF_MASK) mask_reg <= wdata[2:0];
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_read_idle_zero: assert property (!$past(rd && ce) |-> rdata == 32'h0000_0000)
        else $error("rdata not zero outside a read answer");
    chk_ce_read_lost: assert property ($past(rd && !ce) |-> rdata == 32'h0000_0000)
        else $error("read taken while clock enable low");
    chk_unmapped_zero: assert property ($past(rd && ce && addr > rtcb_pkg::OFF_ADJUST)
        |-> rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_ctrl_adj_reads0: assert property (
        $past(rd && ce && addr == rtcb_pkg::OFF_CTRL) |-> rdata[31:12] == 20'h0_0000)
        else $error("control upper bits not zero");
    chk_status_width: assert property (
        $past(rd && ce && addr == rtcb_pkg::OFF_STATUS) |-> rdata[31:3] == 29'h0)
        else $error("status upper bits not zero");
    chk_subsec_width: assert property (
        $past(rd && ce && addr == rtcb_pkg::OFF_SUBSEC) |-> rdata[31:7] == 25'h0)
        else $error("subsecond upper bits not zero");
    chk_mask_readback: assert property ($past(rd && ce && addr == rtcb_pkg::OFF_MASK)
        |-> rdata == {29'h0, $past(mask_reg)})
        else $error("mask read differs from last write");
    chk_irq_masked_low: assert property ($past(mask_reg) == 3'h0 |-> !irq)
        else $error("irq high with all sources masked");
    chk_irq_rise_cause: assert property ($rose(irq) |-> $past(mask_reg) != 3'h0)
        else $error("irq rose without an unmasked source");
endmodule // rtcb_top_sva

bind rtcb_top rtcb_top_sva #(.PRE_W(PRE_W)) rtcb_top_sva_i (
    .clock(clock), .rstn(rstn), .ce(ce), .subclock_osc_in(subclock_osc_in),
    .main_osc_in(main_osc_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .clk_out(clk_out)
);

// ---- tb/rtcb_top_test.sv ----
`timescale 1ns/1ps
module rtcb_top_test;
    logic clock, rstn, ce, sub, wr, rd, irq, clk_out;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, cyc, t0, v;
    int err_total, checks_done;
    rtcb_top #(.PRE_W(8)) rtcb_top_i (
        .clock(clock), .rstn(rstn), .ce(ce), .subclock_osc_in(sub), .main_osc_in(cyc[1]),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .clk_out(clk_out)
    );
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Fast count sources: sub rises every two clocks, main every four
    always @(posedge clock) begin
        sub <= ~sub;
        cyc <= cyc + 32'h0000_0001;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results();
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] g;
        rreg(a, g);
        chk(n, g, e);
    endtask
    // Wait for irq (c=0) or clk_out (c=1) to reach a level
    task automatic wsig(input bit c, input logic lv, input int lim);
        int n;
        n = 0;
        @(negedge clock);
        while ((c ? clk_out : irq) !== lv && n < lim) begin
            @(negedge clock);
            n++;
        end
        if ((c ? clk_out : irq) !== lv) begin
            err_total++;
            results();
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rchk("ctrl", rtcb_pkg::OFF_CTRL, 32'h0000_0004);
        rchk("status", rtcb_pkg::OFF_STATUS, 32'h0000_0000);
        rchk("time", rtcb_pkg::OFF_TIME, 32'h0000_0000);
        rchk("date", rtcb_pkg::OFF_DATE, 32'h0000_0101);
        rchk("bincnt", rtcb_pkg::OFF_BINCNT, 32'h0000_0000);
        rchk("unmapped", 8'h34, 32'h0000_0000);
        wreg(rtcb_pkg::OFF_CTRL, 32'h0000_0006);
        wreg(rtcb_pkg::OFF_BINCNT, 32'hFFFF_FFFE);
        rchk("bincnt load", rtcb_pkg::OFF_BINCNT, 32'hFFFF_FFFE);
        rchk("binary mode", rtcb_pkg::OFF_CTRL, 32'h0000_0006);
        @(posedge clock);
        ce <= 1'b0;
        wreg(rtcb_pkg::OFF_MASK, 32'h0000_0007);
        rreg(rtcb_pkg::OFF_MASK, v);
        @(posedge clock);
        ce <= 1'b1;
        chk("ce read", v, 32'h0000_0000);
        rchk("mask", rtcb_pkg::OFF_MASK, 32'h0000_0000);
    endtask
    task automatic t_adjust();
        wreg(rtcb_pkg::OFF_CTRL, 32'h0000_0005);
        wreg(rtcb_pkg::OFF_TIME, 32'h0010_1529);
        wreg(rtcb_pkg::OFF_CTRL, 32'h0001_0005);
        rchk("adj low", rtcb_pkg::OFF_TIME, 32'h0010_1500);
        wreg(rtcb_pkg::OFF_DATE, 32'h0099_1231);
        wreg(rtcb_pkg::OFF_TIME, 32'h0023_5945);
        wreg(rtcb_pkg::OFF_CTRL, 32'h0001_0005);
        rchk("adj high", rtcb_pkg::OFF_TIME, 32'h0100_0000);
        rchk("adj date", rtcb_pkg::OFF_DATE, 32'h0000_0101);
        // Alarm on minutes only, evaluated after each adjust
        wreg(rtcb_pkg::OFF_ALM_TIME, 32'h0000_0100);
        wreg(rtcb_pkg::OFF_ALM_EN, 32'h0000_0002);
        wreg(rtcb_pkg::OFF_STATUS, 32'h0000_0007);
        wreg(rtcb_pkg::OFF_CTRL, 32'h0001_0005);
        rchk("alarm miss", rtcb_pkg::OFF_STATUS, 32'h0000_0000);
        wreg(rtcb_pkg::OFF_TIME, 32'h0000_0030);
        wreg(rtcb_pkg::OFF_CTRL, 32'h0001_0005);
        rchk("alarm hit", rtcb_pkg::OFF_STATUS, 32'h0000_0001);
    endtask
    task automatic t_period();
        wreg(rtcb_pkg::OFF_MASK, 32'h0000_0002);
        for (int k = 0; k < 5; k++) begin
            wreg(rtcb_pkg::OFF_CTRL, 32'h0000_0605 + (k << 8));
            wsig(0, 1'b1, 9000);
            wreg(rtcb_pkg::OFF_STATUS, 32'h0000_0007);
            wsig(0, 1'b1, 9000);
            t0 = cyc;
            wreg(rtcb_pkg::OFF_STATUS, 32'h0000_0002);
            wsig(0, 1'b1, 9000);
            chk("period", cyc - t0, 32'h0000_0100 << k);
            wreg(rtcb_pkg::OFF_STATUS, 32'h0000_0002);
        end
        wreg(rtcb_pkg::OFF_CTRL, 32'h0000_0005);
        wreg(rtcb_pkg::OFF_STATUS, 32'h0000_0007);
        repeat (600) @(posedge clock);
        rchk("no period", rtcb_pkg::OFF_STATUS, 32'h0000_0000);
    endtask
    task automatic t_subsec();
        rreg(rtcb_pkg::OFF_SUBSEC, t0);
        repeat (510) @(posedge clock);
        rreg(rtcb_pkg::OFF_SUBSEC, v);
        chk("subsec step", v, (t0 + 32'h0000_0001) & 32'h0000_007F);
        wreg(rtcb_pkg::OFF_CTRL, 32'h0000_0004);
        rreg(rtcb_pkg::OFF_SUBSEC, t0);
        repeat (1000) @(posedge clock);
        rchk("stopped", rtcb_pkg::OFF_SUBSEC, t0);
    endtask
    task automatic t_clkout();
        wreg(rtcb_pkg::OFF_CTRL, 32'h0000_000D);
        wsig(1, 1'b0, 2000);
        wsig(1, 1'b1, 2000);
        t0 = cyc;
        wsig(1, 1'b0, 2000);
        chk("clk64 high", cyc - t0, 32'h0000_0200);
        // Main source runs at half the rate of the sub source here
        wreg(rtcb_pkg::OFF_CTRL, 32'h0000_001D);
        wsig(1, 1'b0, 3000);
        wsig(1, 1'b1, 3000);
        t0 = cyc;
        wsig(1, 1'b0, 3000);
        chk("main source", cyc - t0, 32'h0000_0400);
    endtask
    task automatic t_second();
        wreg(rtcb_pkg::OFF_CTRL, 32'h0000_0001);
        wreg(rtcb_pkg::OFF_DATE, 32'h0024_0228);
        wreg(rtcb_pkg::OFF_TIME, 32'h0B11_5959);
        wreg(rtcb_pkg::OFF_ALM_EN, 32'h0000_0000);
        wreg(rtcb_pkg::OFF_STATUS, 32'h0000_0007);
        wreg(rtcb_pkg::OFF_MASK, 32'h0000_0005);
        wsig(0, 1'b1, 70000);
        repeat (4) @(posedge clock);
        rchk("second status", rtcb_pkg::OFF_STATUS, 32'h0000_0005);
        rchk("12h roll", rtcb_pkg::OFF_TIME, 32'h0412_0000);
        rchk("leap day", rtcb_pkg::OFF_DATE, 32'h0024_0229);
        wreg(rtcb_pkg::OFF_STATUS, 32'h0000_0005);
        rchk("cleared", rtcb_pkg::OFF_STATUS, 32'h0000_0000);
        chk("irq low", {31'h0, irq}, 32'h0000_0000);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        sub = 1'b0;
        cyc = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        err_total = 0;
        checks_done = 0;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        t_reset();
        t_adjust();
        t_period();
        t_subsec();
        t_clkout();
        t_second();
        results();
    end
endmodule // rtcb_top_test
